// [design/quad_flash_read_program_erase.sv]
// serial NOR flash command sequencer: quad reads, page programs, sector erase
// Functional notes
// - quad read EBh takes address, mode, four dummy clocks on four lines, returns nibbles.
// - reads start anywhere and the address steps by one per byte shifted out.
// - mode bits 5:4 equal 10 make the next select start straight with address.
// - any other mode bits leave continuous mode; next select needs an opcode.
// - a continuous-mode reset clears the mode and restores opcode decoding.
// - word read E7h needs an even address and only two dummy clocks.
// - word read supports continuous mode the same way, dropping its opcode.
// - program data past the page end wraps to the page start.
// - beyond 256 bytes only the last 256 are programmed.
// - fewer bytes program their own locations and leave the rest of the page alone.
// - program executes only if select rises right after a whole data byte.
// - valid program starts a timed cycle, write-in-progress high, status still readable.
// - write enable latch clears before each program or erase cycle ends.
// - program into a protected page is ignored.
// - quad page program 32h uses four data lines only with quad enable set.
// - four-line page program carries address and data on four lines.
// - sector erase 20h clears the whole 4 KB sector containing the address.
// - sector erase executes only if select rises right after the address.
// - valid sector erase starts a timed cycle with write-in-progress high.
// - sector erase into a protected region is ignored.
// - opcode 06h sets the write enable latch needed by program and erase.
// - 05h returns status 7..0, 35h returns status 15..8, even while busy.
`timescale 1ns/1ps
`default_nettype none
module quad_flash_read_program_erase
  import flash_seq_pkg::*;
#(
  parameter int PROGRAM_CLKS = PROGRAM_CYCLE_CLKS,
  parameter int ERASE_CLKS = SECTOR_ERASE_CLKS
)
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic SCLK,
  input wire logic CS_N,
  input wire logic [3:0] IO_IN,
  output logic [3:0] IO_OUT,
  output logic [3:0] IO_OE_N,
  input wire logic QUAD_ENABLE,
  input wire logic [3:0] BLOCK_PROTECT,
  output logic WRITE_IN_PROGRESS,
  output logic WRITE_ENABLE_LATCH,
  output logic CONTINUOUS_READ
);
  link_t lk1;
  link_t lk2;
  logic sclk_d;
  logic cs_d;
  state_t state;
  logic [4:0] cnt;
  logic [7:0] opcode;
  logic [23:0] addr;
  logic quad_in;
  logic data_quad;
  logic lo;
  logic cont;
  logic cont_word;
  logic [2:0] bcnt;
  logic [7:0] dbyte;
  logic [7:0] col;
  logic got_byte;
  logic began_busy;
  logic [7:0] pbuf [0:255];
  logic [255:0] pvalid;
  logic [7:0] mem [0:(1 << MEM_AW) - 1];
  logic [7:0] mem_q;
  logic write_in_progress;
  logic write_enable_latch;
  logic erasing;
  logic [23:0] base;
  logic [TIMER_W-1:0] timer;
  logic [SECTOR_AW-1:0] walk;
  logic walk_done;
  logic [2:0] sbit;
  logic [3:0] io_out;
  logic [3:0] io_oe_n;

  // only the second stage is read; edges come from it against a third copy
  always_ff @(posedge CLK)
  begin
    lk1 <= '{sclk: SCLK, cs_n: CS_N, io: IO_IN};
    lk2 <= lk1;
    sclk_d <= lk2.sclk;
    cs_d <= lk2.cs_n;
  end

  wire logic rise = !lk2.cs_n && lk2.sclk && !sclk_d;
  wire logic fall = !lk2.cs_n && !lk2.sclk && sclk_d;
  wire logic cs_rise = lk2.cs_n && !cs_d;
  wire logic cs_fall = !lk2.cs_n && cs_d;
  wire logic [7:0] next_op = {opcode[6:0], lk2.io[0]};
  wire logic [23:0] next_addr = quad_in ? {addr[19:0], lk2.io} : {addr[22:0], lk2.io[0]};
  wire logic [7:0] next_byte = data_quad ? {dbyte[3:0], lk2.io} : {dbyte[6:0], lk2.io[0]};
  wire logic byte_done = rise && state == ST_PDATA && bcnt == (data_quad ? BIT_LAST_QUAD : BIT_LAST_SINGLE);

  // upper part of the array is protected: 2^(bp-1) top 64 KB blocks, all from bp=5
  function automatic logic protect(input logic [3:0] bp, input logic [23:0] a);
    logic [4:0] span;
    span = 5'h00;
    if (bp != 4'h0)
    begin
      span = (bp >= 4'h5) ? 5'h10 : 5'(5'h01 << (bp - 4'h1));
    end
    protect = ({1'b0, a[19:16]} >= 5'(5'h10 - span)) && (span != 5'h00);
  endfunction

  wire logic prot = protect(BLOCK_PROTECT, addr);
  wire logic prog_go = cs_rise && state == ST_PDATA && bcnt == 3'h0 && got_byte
                       && write_enable_latch && !write_in_progress && !began_busy && !prot;
  wire logic erase_go = cs_rise && state == ST_IGNORE && opcode == OP_SECTOR_ERASE && cnt == 5'h00
                        && write_enable_latch && !write_in_progress && !began_busy && !prot;
  wire logic end8 = cs_rise && state == ST_IGNORE && cnt == 5'h00;

  // command, address, mode and dummy phases; continuous mode bookkeeping
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      state <= ST_IDLE;
      cnt <= 5'h00;
      opcode <= 8'h00;
      addr <= 24'h000000;
      quad_in <= 1'b0;
      data_quad <= 1'b0;
      lo <= 1'b0;
      cont <= 1'b0;
      cont_word <= 1'b0;
      bcnt <= 3'h0;
      dbyte <= 8'h00;
      col <= 8'h00;
      got_byte <= 1'b0;
    end
    else if (cs_fall)
    begin
      cnt <= 5'h00;
      lo <= 1'b0;
      bcnt <= 3'h0;
      got_byte <= 1'b0;
      if (cont)
      begin
        state <= ST_ADDR;
        opcode <= cont_word ? OP_QUAD_WORD_READ : OP_QUAD_READ;
        quad_in <= 1'b1;
      end
      else
      begin
        state <= ST_CMD;
        quad_in <= 1'b0;
      end
    end
    else if (lk2.cs_n)
    begin
      state <= ST_IDLE;
    end
    else if (rise)
    begin
      case (state)
        ST_CMD:
        begin
          opcode <= next_op;
          cnt <= cnt + 5'h01;
          if (cnt == CMD_LAST)
          begin
            cnt <= 5'h00;
            state <= ST_IGNORE;
            case (next_op)
              OP_QUAD_READ, OP_QUAD_WORD_READ:
              begin
                if (QUAD_ENABLE && !write_in_progress)
                begin
                  state <= ST_ADDR;
                  quad_in <= 1'b1;
                end
              end
              OP_PAGE_PROGRAM, OP_SECTOR_ERASE:
              begin
                state <= ST_ADDR;
                data_quad <= 1'b0;
              end
              OP_QUAD_PAGE_PROGRAM:
              begin
                state <= ST_ADDR;
                data_quad <= QUAD_ENABLE;
              end
              OP_FOUR_LINE_PP:
              begin
                if (QUAD_ENABLE)
                begin
                  state <= ST_ADDR;
                  quad_in <= 1'b1;
                  data_quad <= 1'b1;
                end
              end
              OP_READ_STATUS_LO, OP_READ_STATUS_HI:
              begin
                state <= ST_STATUS;
              end
              OP_CONT_RESET:
              begin
                cont <= 1'b0;
              end
              default:
              begin
                state <= ST_IGNORE;
              end
            endcase
          end
        end
        ST_ADDR:
        begin
          addr <= next_addr;
          cnt <= cnt + 5'h01;
          if (cnt == (quad_in ? ADDR_LAST_QUAD : ADDR_LAST_SINGLE))
          begin
            cnt <= 5'h00;
            col <= next_addr[7:0];
            if (opcode == OP_QUAD_READ || opcode == OP_QUAD_WORD_READ)
            begin
              state <= ST_MODE;
            end
            else if (opcode == OP_SECTOR_ERASE)
            begin
              state <= ST_IGNORE;
            end
            else
            begin
              state <= ST_PDATA;
            end
          end
        end
        ST_MODE:
        begin
          cnt <= cnt + 5'h01;
          if (cnt == 5'h00)
          begin
            // the first nibble carries mode bits 7..4
            cont <= (lk2.io[1:0] == CONT_KEEP);
            cont_word <= (opcode == OP_QUAD_WORD_READ);
          end
          if (cnt == MODE_LAST)
          begin
            cnt <= 5'h00;
            state <= ST_DUMMY;
          end
        end
        ST_DUMMY:
        begin
          cnt <= cnt + 5'h01;
          if (cnt == ((opcode == OP_QUAD_WORD_READ) ? DUMMY_LAST_WORD : DUMMY_LAST_QUAD))
          begin
            state <= ST_READ;
          end
        end
        ST_PDATA:
        begin
          dbyte <= next_byte;
          bcnt <= byte_done ? 3'h0 : bcnt + 3'h1;
          if (byte_done)
          begin
            col <= col + 8'h01;
            got_byte <= 1'b1;
          end
        end
        ST_IGNORE:
        begin
          cnt <= 5'h01; // any extra clock spoils an exact-length command
        end
        default:
        begin
          state <= state;
        end
      endcase
    end
    else if (fall && state == ST_READ)
    begin
      lo <= !lo;
      if (lo)
      begin
        addr <= addr + 24'h000001;
      end
    end
  end

  // a program or erase that opens while busy stays refused, even if the cycle ends under it
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      began_busy <= 1'b0;
    end
    else if (cs_fall)
    begin
      began_busy <= write_in_progress;
    end
  end

  // page buffer holds the last byte written at each column of the page;
  // the walker still reads it while busy, so a refused command leaves it alone
  always_ff @(posedge CLK)
  begin
    if (RST || (cs_fall && !write_in_progress))
    begin
      pvalid <= '0;
    end
    else if (byte_done && !began_busy)
    begin
      pbuf[col] <= next_byte;
      pvalid[col] <= 1'b1;
    end
  end

  // self-timed cycle: a walker touches the array, the timer sets the length
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      write_in_progress <= 1'b0;
      erasing <= 1'b0;
      base <= 24'h000000;
      timer <= '0;
      walk <= '0;
      walk_done <= 1'b0;
    end
    else if (!write_in_progress && (prog_go || erase_go))
    begin
      write_in_progress <= 1'b1;
      erasing <= erase_go;
      base <= addr;
      timer <= '0;
      walk <= '0;
      walk_done <= 1'b0;
    end
    else if (write_in_progress)
    begin
      timer <= timer + 1'b1;
      if (!walk_done)
      begin
        walk <= walk + 1'b1;
        walk_done <= erasing ? (walk == '1) : (walk[PAGE_AW-1:0] == 8'hFF);
      end
      if (walk_done && timer >= TIMER_W'((erasing ? ERASE_CLKS : PROGRAM_CLKS) - 1))
      begin
        write_in_progress <= 1'b0;
      end
    end
  end

  // single array port; reads are refused while busy, so the walker owns it then
  always_ff @(posedge CLK)
  begin
    mem_q <= mem[addr[MEM_AW-1:0]];
    if (write_in_progress && !walk_done)
    begin
      if (erasing)
      begin
        mem[{base[MEM_AW-1:SECTOR_AW], walk}] <= ERASED_BYTE;
      end
      else if (pvalid[walk[PAGE_AW-1:0]])
      begin
        mem[{base[MEM_AW-1:PAGE_AW], walk[PAGE_AW-1:0]}] <=
          mem[{base[MEM_AW-1:PAGE_AW], walk[PAGE_AW-1:0]}] & pbuf[walk[PAGE_AW-1:0]];
      end
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      write_enable_latch <= 1'b0;
    end
    else if (prog_go || erase_go)
    begin
      write_enable_latch <= 1'b0;
    end
    else if (end8 && opcode == OP_WRITE_ENABLE)
    begin
      write_enable_latch <= 1'b1;
    end
    else if (end8 && opcode == OP_WRITE_DISABLE && !write_in_progress)
    begin
      write_enable_latch <= 1'b0;
    end
  end

  wire logic [7:0] stat_lo = {2'b00, BLOCK_PROTECT, write_enable_latch, write_in_progress};
  wire logic [7:0] stat_hi = {6'h00, QUAD_ENABLE, 1'b0};
  wire logic [7:0] stat = (opcode == OP_READ_STATUS_HI) ? stat_hi : stat_lo;

  // output nibbles change on serial clock falls
  always_ff @(posedge CLK)
  begin
    if (RST || lk2.cs_n)
    begin
      io_out <= 4'h0;
      io_oe_n <= 4'hF;
      sbit <= STATUS_FIRST_BIT;
    end
    else if (fall && state == ST_READ)
    begin
      io_out <= lo ? mem_q[3:0] : mem_q[7:4];
      io_oe_n <= 4'h0;
    end
    else if (fall && state == ST_STATUS)
    begin
      io_out <= {2'b00, stat[sbit], 1'b0};
      io_oe_n <= 4'hD;
      sbit <= sbit - 3'h1;
    end
  end

  assign IO_OUT = io_out;
  assign IO_OE_N = io_oe_n;
  assign WRITE_IN_PROGRESS = write_in_progress;
  assign WRITE_ENABLE_LATCH = write_enable_latch;
  assign CONTINUOUS_READ = cont;
endmodule
`default_nettype wire

// [design/flash_seq_pkg.sv]
// shared constants and types of the quad serial flash command sequencer
package flash_seq_pkg;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_READ_STATUS_LO = 8'h05;
  localparam logic [7:0] OP_READ_STATUS_HI = 8'h35;
  localparam logic [7:0] OP_QUAD_READ = 8'hEB;
  localparam logic [7:0] OP_QUAD_WORD_READ = 8'hE7;
  localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] OP_QUAD_PAGE_PROGRAM = 8'h32;
  // opcode of the four-line page program is not fixed elsewhere; plain default
  localparam logic [7:0] OP_FOUR_LINE_PP = 8'h38;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] OP_CONT_RESET = 8'hFF;
  localparam logic [1:0] CONT_KEEP = 2'b10;
  localparam int MEM_AW = 13;
  localparam int PAGE_AW = 8;
  localparam int SECTOR_AW = 12;
  localparam logic [4:0] ADDR_LAST_SINGLE = 5'h17;
  localparam logic [4:0] ADDR_LAST_QUAD = 5'h05;
  localparam logic [4:0] CMD_LAST = 5'h07;
  localparam logic [4:0] MODE_LAST = 5'h01;
  localparam logic [4:0] DUMMY_LAST_QUAD = 5'h03;
  localparam logic [4:0] DUMMY_LAST_WORD = 5'h01;
  localparam logic [2:0] BIT_LAST_SINGLE = 3'h7;
  localparam logic [2:0] BIT_LAST_QUAD = 3'h1;
  localparam logic [2:0] STATUS_FIRST_BIT = 3'h7;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam int CLK_MHZ = 50;
  localparam int PROGRAM_CYCLE_TIME_US = 500;
  localparam int SECTOR_ERASE_TIME_US = 5000;
  localparam int PROGRAM_CYCLE_CLKS = PROGRAM_CYCLE_TIME_US * CLK_MHZ;
  localparam int SECTOR_ERASE_CLKS = SECTOR_ERASE_TIME_US * CLK_MHZ;
  localparam int TIMER_W = 32;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_CMD = 4'h1,
    ST_ADDR = 4'h3,
    ST_MODE = 4'h2,
    ST_DUMMY = 4'h6,
    ST_READ = 4'h7,
    ST_PDATA = 4'h5,
    ST_STATUS = 4'h4,
    ST_IGNORE = 4'hC
  } state_t;

  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic [3:0] io;
  } link_t;
endpackage

// [sim/quad_flash_props.sv]
// port checks of the quad flash command sequencer
`timescale 1ns/1ps
`default_nettype none
module quad_flash_props
  import flash_seq_pkg::*;
#(
  parameter int PROGRAM_CLKS = 300,
  parameter int ERASE_CLKS = 5000
)
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic SCLK,
  input wire logic CS_N,
  input wire logic [3:0] IO_IN,
  input wire logic [3:0] IO_OUT,
  input wire logic [3:0] IO_OE_N,
  input wire logic QUAD_ENABLE,
  input wire logic [3:0] BLOCK_PROTECT,
  input wire logic WRITE_IN_PROGRESS,
  input wire logic WRITE_ENABLE_LATCH,
  input wire logic CONTINUOUS_READ
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  int busy_clks;
  // counts busy edges so the fall can be tied to the cycle length
  always_ff @(posedge CLK)
    if (RST || !WRITE_IN_PROGRESS)
      busy_clks <= 0;
    else
      busy_clks <= busy_clks + 1;
  property p_idle_lanes;
    CS_N [*8] |-> IO_OE_N == 4'hF;
  endproperty
  a_idle_lanes: assert property (p_idle_lanes) else $error("lanes driven while deselected");
  property p_no_quad;
    !QUAD_ENABLE && !CONTINUOUS_READ |-> IO_OE_N[3:2] == 2'b11;
  endproperty
  a_no_quad: assert property (p_no_quad) else $error("quad lanes driven without quad enable");
  property p_busy_start;
    $rose(WRITE_IN_PROGRESS) |-> $past(CS_N, 2);
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("busy began while selected");
  property p_latch_drop;
    $rose(WRITE_IN_PROGRESS) |-> ##[0:2] !WRITE_ENABLE_LATCH;
  endproperty
  a_latch_drop: assert property (p_latch_drop) else $error("latch kept in cycle");
  property p_latch_needed;
    $rose(WRITE_IN_PROGRESS) |-> $past(WRITE_ENABLE_LATCH, 3);
  endproperty
  a_latch_needed: assert property (p_latch_needed) else $error("cycle without latch");
  property p_protect;
    $rose(WRITE_IN_PROGRESS) |-> $past(BLOCK_PROTECT) < 4'h5;
  endproperty
  a_protect: assert property (p_protect) else $error("cycle in protected area");
  property p_busy_len;
    $fell(WRITE_IN_PROGRESS) |-> busy_clks inside {[PROGRAM_CLKS-2:PROGRAM_CLKS+2], [ERASE_CLKS-2:ERASE_CLKS+2]};
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("cycle length wrong");
  property p_busy_lanes;
    WRITE_IN_PROGRESS |-> IO_OE_N[0] && IO_OE_N[3:2] == 2'b11;
  endproperty
  a_busy_lanes: assert property (p_busy_lanes) else $error("data lanes driven while busy");
  property p_cont_qe;
    $rose(CONTINUOUS_READ) |-> QUAD_ENABLE;
  endproperty
  a_cont_qe: assert property (p_cont_qe) else $error("continuous mode without quad enable");
  c_busy: cover property ($rose(WRITE_IN_PROGRESS));
  c_cont: cover property ($rose(CONTINUOUS_READ));
  c_quad: cover property (IO_OE_N == 4'h0);
endmodule
bind quad_flash_read_program_erase quad_flash_props #(.PROGRAM_CLKS(PROGRAM_CLKS), .ERASE_CLKS(ERASE_CLKS))
  i_quad_flash_props (.CLK(CLK), .RST(RST), .SCLK(SCLK), .CS_N(CS_N), .IO_IN(IO_IN), .IO_OUT(IO_OUT),
  .IO_OE_N(IO_OE_N), .QUAD_ENABLE(QUAD_ENABLE), .BLOCK_PROTECT(BLOCK_PROTECT),
  .WRITE_IN_PROGRESS(WRITE_IN_PROGRESS), .WRITE_ENABLE_LATCH(WRITE_ENABLE_LATCH),
  .CONTINUOUS_READ(CONTINUOUS_READ));
`default_nettype wire

// [sim/spi_host.sv]
// host controller model: select, serial clock and the four IO lanes
`timescale 1ns/1ps
`default_nettype none
module spi_host
  import flash_seq_pkg::*;
(
  input wire logic clk,
  input wire logic [3:0] io_out,
  input wire logic [3:0] io_oe_n,
  output var link_t link
);
  logic sclk = 1'b0;
  logic cs_n = 1'b1;
  logic tog = 1'b0;
  logic [3:0] own = 4'h0;
  logic [3:0] drv = 4'h0;
  logic [3:0] seen;
  logic [3:0] host_io;
  logic [7:0] rd [4];
  // undriven lanes change every clock so a stale level never passes for data
  always_ff @(posedge clk)
    tog <= ~tog;
  assign host_io = (own & drv) | (~own & {tog, ~tog, tog, ~tog});
  assign link = '{sclk: sclk, cs_n: cs_n, io: (io_oe_n & host_io) | (~io_oe_n & io_out)};
  task automatic tick(input logic [3:0] m, input logic [3:0] d);
    @(posedge clk);
    sclk <= 1'b0;
    own <= m;
    drv <= d;
    repeat (4) @(posedge clk);
    sclk <= 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    seen = link.io;
  endtask
  task automatic put(input logic [7:0] b, input logic quad);
    if (quad)
    begin
      tick(4'hF, b[7:4]);
      tick(4'hF, b[3:0]);
    end
    else
      for (int i = 7; i >= 0; i--)
        tick(4'h1, {3'h0, b[i]});
  endtask
  // select only moves with the clock low, after a whole unit
  task automatic sel(input logic on);
    @(posedge clk);
    sclk <= 1'b0;
    cs_n <= ~on;
    own <= 4'h0;
    repeat (8) @(posedge clk);
  endtask
  task automatic cmd(input logic [7:0] op, input logic [23:0] a, input int na, input logic quad);
    sel(1'b1);
    if (op != 8'h00)
      put(op, 1'b0);
    for (int i = na - 1; i >= 0; i--)
      put(a[8*i +: 8], quad);
  endtask
  task automatic qread(input logic [7:0] op, input logic [23:0] a, input logic [7:0] m, input int dum, input int n);
    cmd(op, a, 3, 1'b1);
    put(m, 1'b1);
    repeat (dum)
      tick(4'h0, 4'h0);
    for (int i = 0; i < n; i++)
    begin
      tick(4'h0, 4'h0);
      rd[i][7:4] = seen;
      tick(4'h0, 4'h0);
      rd[i][3:0] = seen;
    end
    sel(1'b0);
  endtask
  task automatic status(input logic [7:0] op, output logic [7:0] s);
    cmd(op, 24'h0, 0, 1'b0);
    for (int i = 7; i >= 0; i--)
    begin
      tick(4'h1, 4'h0);
      s[i] = seen[1];
    end
    sel(1'b0);
  endtask
endmodule
`default_nettype wire

// [sim/quad_flash_read_program_erase_tb_top.sv]
// self-checking bench of the quad flash command sequencer
`timescale 1ns/1ps
`default_nettype none
module quad_flash_read_program_erase_tb_top;
  import flash_seq_pkg::*;
  logic CLK;
  logic RST;
  logic QUAD_ENABLE;
  logic [3:0] BLOCK_PROTECT;
  logic [3:0] IO_OUT;
  logic [3:0] IO_OE_N;
  logic WRITE_IN_PROGRESS;
  logic WRITE_ENABLE_LATCH;
  logic CONTINUOUS_READ;
  link_t link;
  int n_mismatch = 0;
  int comparisons = 0;
  logic [7:0] st;
  initial
  begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end
  quad_flash_read_program_erase #(.PROGRAM_CLKS(300), .ERASE_CLKS(5000)) i_quad_flash_read_program_erase (
    .CLK(CLK), .RST(RST), .SCLK(link.sclk), .CS_N(link.cs_n), .IO_IN(link.io), .IO_OUT(IO_OUT),
    .IO_OE_N(IO_OE_N), .QUAD_ENABLE(QUAD_ENABLE), .BLOCK_PROTECT(BLOCK_PROTECT),
    .WRITE_IN_PROGRESS(WRITE_IN_PROGRESS), .WRITE_ENABLE_LATCH(WRITE_ENABLE_LATCH),
    .CONTINUOUS_READ(CONTINUOUS_READ));
  spi_host i_spi_host (.clk(CLK), .io_out(IO_OUT), .io_oe_n(IO_OE_N), .link(link));
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic summarize();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic write_enable_cmd();
    i_spi_host.cmd(OP_WRITE_ENABLE, 24'h0, 0, 1'b0);
    i_spi_host.sel(1'b0);
  endtask
  task automatic settle(input int lim);
    int k;
    k = 0;
    while (WRITE_IN_PROGRESS !== 1'b0 && k < lim)
    begin
      @(negedge CLK);
      k++;
    end
    @(posedge CLK);
    if (k >= lim)
    begin
      n_mismatch++;
      $display("Error busy wait expected 0 seen 1");
      summarize();
    end
  endtask
  task automatic program1(input logic [7:0] op, input logic [23:0] a, input logic qa, input logic [7:0] d);
    write_enable_cmd();
    i_spi_host.cmd(op, a, 3, qa);
    i_spi_host.put(d, op != OP_PAGE_PROGRAM);
    i_spi_host.sel(1'b0);
    check("program busy", 8'h01, {7'h0, WRITE_IN_PROGRESS});
    // status read lands while the walker still programs the page
    i_spi_host.status(OP_READ_STATUS_LO, st);
    check("program status", 8'h01, st & 8'h03);
    settle(400);
  endtask
  task automatic t_status_erase();
    BLOCK_PROTECT <= 4'h3;
    write_enable_cmd();
    i_spi_host.status(OP_READ_STATUS_LO, st);
    check("status low", 8'h0E, st);
    i_spi_host.status(OP_READ_STATUS_HI, st);
    check("status high", 8'h02, st);
    BLOCK_PROTECT <= 4'h0;
    i_spi_host.cmd(OP_SECTOR_ERASE, 24'h000ABC, 3, 1'b0);
    i_spi_host.sel(1'b0);
    check("erase busy", 8'h01, {7'h0, WRITE_IN_PROGRESS});
    check("erase latch", 8'h00, {7'h0, WRITE_ENABLE_LATCH});
    i_spi_host.status(OP_READ_STATUS_LO, st);
    check("busy status", 8'h01, st & 8'h03);
    write_enable_cmd();
    i_spi_host.cmd(OP_PAGE_PROGRAM, 24'h000100, 3, 1'b0);
    i_spi_host.put(8'h00, 1'b0);
    i_spi_host.sel(1'b0);
    check("busy refusal", 8'h03, {6'h0, WRITE_ENABLE_LATCH, WRITE_IN_PROGRESS});
    settle(6000);
    write_enable_cmd();
    i_spi_host.cmd(OP_SECTOR_ERASE, 24'h000000, 3, 1'b0);
    i_spi_host.tick(4'h1, 4'h0);
    i_spi_host.sel(1'b0);
    check("late select", 8'h00, {7'h0, WRITE_IN_PROGRESS});
    BLOCK_PROTECT <= 4'h5;
    write_enable_cmd();
    i_spi_host.cmd(OP_SECTOR_ERASE, 24'h000000, 3, 1'b0);
    i_spi_host.sel(1'b0);
    check("protected erase", 8'h00, {7'h0, WRITE_IN_PROGRESS});
    BLOCK_PROTECT <= 4'h0;
    $display("test status and erase done");
  endtask
  task automatic t_program();
    write_enable_cmd();
    i_spi_host.cmd(OP_PAGE_PROGRAM, 24'h0000FE, 3, 1'b0);
    i_spi_host.put(8'hA5, 1'b0);
    i_spi_host.put(8'h3C, 1'b0);
    i_spi_host.put(8'h0F, 1'b0);
    i_spi_host.sel(1'b0);
    settle(400);
    program1(OP_PAGE_PROGRAM, 24'h0000FE, 1'b0, 8'h0F);
    program1(OP_FOUR_LINE_PP, 24'h000020, 1'b1, 8'h96);
    program1(OP_QUAD_PAGE_PROGRAM, 24'h000021, 1'b0, 8'h69);
    write_enable_cmd();
    i_spi_host.cmd(OP_PAGE_PROGRAM, 24'h000010, 3, 1'b0);
    i_spi_host.put(8'h00, 1'b0);
    i_spi_host.tick(4'h1, 4'h0);
    i_spi_host.sel(1'b0);
    check("partial byte", 8'h00, {7'h0, WRITE_IN_PROGRESS});
    // top block protected; the address folds onto 0x10 in the small array
    BLOCK_PROTECT <= 4'h1;
    write_enable_cmd();
    i_spi_host.cmd(OP_PAGE_PROGRAM, 24'h0F0010, 3, 1'b0);
    i_spi_host.put(8'h00, 1'b0);
    i_spi_host.sel(1'b0);
    check("protected program", 8'h02, {6'h0, WRITE_ENABLE_LATCH, WRITE_IN_PROGRESS});
    BLOCK_PROTECT <= 4'h0;
    i_spi_host.qread(OP_QUAD_READ, 24'h0000FE, 8'h00, 4, 3);
    check("only clears", 8'h05, i_spi_host.rd[0]);
    check("next byte", 8'h3C, i_spi_host.rd[1]);
    check("no spill", 8'hFF, i_spi_host.rd[2]);
    i_spi_host.qread(OP_QUAD_READ, 24'h000020, 8'h00, 4, 2);
    check("four line", 8'h96, i_spi_host.rd[0]);
    check("quad program", 8'h69, i_spi_host.rd[1]);
    $display("test program done");
  endtask
  task automatic t_read();
    i_spi_host.qread(OP_QUAD_READ, 24'h000000, 8'h20, 4, 2);
    check("wrap start", 8'h0F, i_spi_host.rd[0]);
    check("untouched", 8'hFF, i_spi_host.rd[1]);
    check("armed", 8'h01, {7'h0, CONTINUOUS_READ});
    i_spi_host.qread(8'h00, 24'h0000FE, 8'h00, 4, 1);
    check("no opcode", 8'h05, i_spi_host.rd[0]);
    check("disarmed", 8'h00, {7'h0, CONTINUOUS_READ});
    i_spi_host.qread(OP_QUAD_WORD_READ, 24'h000010, 8'h20, 2, 2);
    check("word read", 8'hFF, i_spi_host.rd[0]);
    i_spi_host.qread(8'h00, 24'h0000FE, 8'h20, 2, 2);
    check("word cont", 8'h3C, i_spi_host.rd[1]);
    i_spi_host.sel(1'b1);
    repeat (8) i_spi_host.tick(4'hF, 4'hF);
    i_spi_host.sel(1'b0);
    check("mode reset", 8'h00, {7'h0, CONTINUOUS_READ});
    i_spi_host.status(OP_READ_STATUS_HI, st);
    check("opcode again", 8'h02, st);
    QUAD_ENABLE <= 1'b0;
    i_spi_host.qread(OP_QUAD_READ, 24'h000000, 8'h20, 4, 1);
    check("refused read", 8'h00, {7'h0, CONTINUOUS_READ});
    QUAD_ENABLE <= 1'b1;
    $display("test read done");
  endtask
  initial
  begin
    RST <= 1'b1;
    QUAD_ENABLE <= 1'b1;
    BLOCK_PROTECT <= 4'h0;
    repeat (12) @(posedge CLK);
    RST <= 1'b0;
    repeat (4) @(posedge CLK);
    check("reset lanes", 8'h0F, {4'h0, IO_OE_N});
    check("reset flags", 8'h00, {5'h0, WRITE_IN_PROGRESS, WRITE_ENABLE_LATCH, CONTINUOUS_READ});
    t_status_erase();
    t_program();
    t_read();
    summarize();
  end
endmodule
`default_nettype wire
